// *** logic/ndw_pkg.sv ***
// package of constants for the network deadlock watchdog and refill block
// Operation
// (R01) watchdog counter increments by one every cycle unless cleared (the counter stops and holds once it reaches all ones)
// (R02) counter clears when input port is empty or a read succeeds (a refill-mode read does not clear it while the port holds data)
// (R03) counter reaching software threshold raises a deadlock interrupt
// (R04) mode flag places tile in refill mode, reads served from stored words
// (R05) in refill mode, port reads return the refill register contents
// (R06) each refill-mode read interrupts on the instruction right after it
// (R07) handler writes next buffered word into refill register before return
// (R08) when stored words are used up, refill mode clears, network serves again
// (R09) software may raise threshold if slow consumers cause false alarms
// (R10) threshold held in writable register; deadlock interrupt pends until ack
package ndw_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned CNT_W = 32;
	localparam logic [CNT_W-1:0] THRESH_RST = 32'hffffffff;
	localparam logic [DATA_W-1:0] REFILL_RST = 32'h00000000;
	localparam logic [CNT_W-1:0] CNT_RST = 32'h00000000;
endpackage

// *** logic/ndw_counter.sv ***
// watchdog cycle counter with threshold compare
`timescale 1ns/10ps
module ndw_counter #(
	parameter int unsigned W = 32
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_clear,
	input wire logic [W-1:0] i_thresh,
	output logic o_hit
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic hit_q;
	logic hit_d;
	always_comb begin
		cnt_d = cnt_q;
		// (R02) clear on empty or read
		if (i_clear) begin
			cnt_d = '0;
		// (R01) count every cycle until all ones, then hold
		end else if (cnt_q != {W{1'b1}}) begin
			cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
		end
		// (R03) threshold reached
		hit_d = !i_clear && (cnt_d == i_thresh);
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= W'(ndw_pkg::CNT_RST);
			hit_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			hit_q <= hit_d;
		end
	end
	assign o_hit = hit_q;
endmodule

// *** logic/ndw_top.sv ***
// deadlock watchdog and refill mode for the general network input port
`timescale 1ns/10ps
module ndw_top #(
	parameter int unsigned DATA_W = ndw_pkg::DATA_W,
	parameter int unsigned CNT_W = ndw_pkg::CNT_W
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_port_valid,
	input wire logic [DATA_W-1:0] i_port_data,
	input wire logic i_port_read,
	input wire logic i_thresh_we,
	input wire logic [CNT_W-1:0] i_thresh_wdata,
	input wire logic i_dl_ack,
	input wire logic i_refill_set,
	input wire logic i_refill_clr,
	input wire logic i_refill_we,
	input wire logic [DATA_W-1:0] i_refill_wdata,
	input wire logic i_refill_last,
	output logic [DATA_W-1:0] o_read_data,
	output logic o_read_valid,
	output logic o_port_pop,
	output logic o_refill_mode,
	output logic o_dl_irq,
	output logic o_refill_irq,
	output logic [CNT_W-1:0] o_thresh
);
	logic [CNT_W-1:0] thresh_q;
	logic [CNT_W-1:0] thresh_d;
	logic mode_q;
	logic mode_d;
	logic last_q;
	logic last_d;
	logic [DATA_W-1:0] refill_q;
	logic [DATA_W-1:0] refill_d;
	logic dl_q;
	logic dl_d;
	logic rirq_q;
	logic rirq_d;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic rvalid_q;
	logic rvalid_d;
	logic pop_q;
	logic pop_d;
	logic hit;
	logic net_read;
	logic ref_read;
	logic wd_clear;

	// (R04) reads go to the refill register while in refill mode
	always_comb begin
		net_read = 1'b0;
		ref_read = 1'b0;
		if (i_port_read) begin
			if (mode_q) begin
				ref_read = 1'b1;
			end else if (i_port_valid) begin
				net_read = 1'b1;
			end
		end
	end

	// (R02) empty port or network read clears the count
	always_comb begin
		wd_clear = 1'b0;
		if (!i_port_valid) begin
			wd_clear = 1'b1;
		end else if (net_read) begin
			wd_clear = 1'b1;
		end
	end

	ndw_counter #(
		.W(CNT_W)
	) u_counter (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_clear(wd_clear),
		.i_thresh(thresh_q),
		.o_hit(hit)
	);

	// (R10) writable threshold
	always_comb begin
		thresh_d = thresh_q;
		if (i_thresh_we) begin
			thresh_d = i_thresh_wdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			thresh_q <= CNT_W'(ndw_pkg::THRESH_RST);
		end else begin
			thresh_q <= thresh_d;
		end
	end

	// (R03) threshold hit raises the deadlock interrupt
	// (R10) pending until ack, set wins
	always_comb begin
		dl_d = dl_q;
		if (hit) begin
			dl_d = 1'b1;
		end else if (i_dl_ack) begin
			dl_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			dl_q <= 1'b0;
		end else begin
			dl_q <= dl_d;
		end
	end

	// (R05) refill word loaded by the handler
	always_comb begin
		refill_d = refill_q;
		if (i_refill_we) begin
			refill_d = i_refill_wdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			refill_q <= DATA_W'(ndw_pkg::REFILL_RST);
		end else begin
			refill_q <= refill_d;
		end
	end

	// (R04) mode flag set and clear
	always_comb begin
		mode_d = mode_q;
		last_d = last_q;
		if (i_refill_set) begin
			last_d = 1'b0;
		end
		if (i_refill_we) begin
			last_d = i_refill_last;
		end
		if (i_refill_set) begin
			mode_d = 1'b1;
		end else if (i_refill_clr) begin
			mode_d = 1'b0;
		// (R08) last stored word consumed
		end else if (ref_read && last_q) begin
			mode_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			last_q <= last_d;
		end
	end

	// (R06) interrupt after every refill read
	always_comb begin
		rirq_d = 1'b0;
		if (ref_read) begin
			rirq_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rirq_q <= 1'b0;
		end else begin
			rirq_q <= rirq_d;
		end
	end

	// (R05) serve from refill register
	always_comb begin
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		if (ref_read) begin
			rdata_d = refill_q;
			rvalid_d = 1'b1;
		end else if (net_read) begin
			rdata_d = i_port_data;
			rvalid_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= DATA_W'(ndw_pkg::REFILL_RST);
			rvalid_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// (R04) only network reads dequeue the port
	always_comb begin
		pop_d = 1'b0;
		if (net_read) begin
			pop_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pop_q <= 1'b0;
		end else begin
			pop_q <= pop_d;
		end
	end

	assign o_thresh = thresh_q;
	assign o_dl_irq = dl_q;
	assign o_refill_irq = rirq_q;
	assign o_refill_mode = mode_q;
	assign o_read_data = rdata_q;
	assign o_read_valid = rvalid_q;
	assign o_port_pop = pop_q;
endmodule

// *** bench/ndw_chk.sv ***
// port assertions for the deadlock watchdog block
`timescale 1ns/10ps
module ndw_chk #(
	parameter int unsigned CNT_W = 32
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_port_valid,
	input wire logic i_port_read,
	input wire logic i_thresh_we,
	input wire logic [CNT_W-1:0] i_thresh_wdata,
	input wire logic i_dl_ack,
	input wire logic i_refill_set,
	input wire logic i_refill_clr,
	input wire logic o_read_valid,
	input wire logic o_port_pop,
	input wire logic o_refill_mode,
	input wire logic o_dl_irq,
	input wire logic o_refill_irq,
	input wire logic [CNT_W-1:0] o_thresh
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_rd;
		i_port_read && (o_refill_mode || i_port_valid);
	endsequence
	sequence s_ref_rd;
		i_port_read && o_refill_mode;
	endsequence
	property p_rv; s_rd |=> o_read_valid; endproperty
	a_rv: assert property (p_rv) else $error("read lost");
	property p_pop;
		o_port_pop |-> $past(i_port_read) && !$past(o_refill_mode);
	endproperty
	a_pop: assert property (p_pop) else $error("bad pop");
	property p_ri;
		o_refill_irq |-> $past(i_port_read) && $past(o_refill_mode);
	endproperty
	a_ri: assert property (p_ri) else $error("bad irq");
	property p_rirq; s_ref_rd |=> o_refill_irq && !o_port_pop; endproperty
	a_rirq: assert property (p_rirq) else $error("no refill irq");
	property p_dl; o_dl_irq |=> o_dl_irq || $past(i_dl_ack); endproperty
	a_dl: assert property (p_dl) else $error("irq dropped");
	property p_dlr;
		$rose(o_dl_irq) |-> $past(i_port_valid, 2) &&
			!($past(i_port_read, 2) && !$past(o_refill_mode, 2));
	endproperty
	a_dlr: assert property (p_dlr) else $error("irq on idle port");
	property p_th; i_thresh_we |=> o_thresh == $past(i_thresh_wdata);
	endproperty
	a_th: assert property (p_th) else $error("thresh");
	property p_set; i_refill_set |=> o_refill_mode; endproperty
	a_set: assert property (p_set) else $error("no mode");
	property p_clr; i_refill_clr && !i_refill_set |=> !o_refill_mode;
	endproperty
	a_clr: assert property (p_clr) else $error("mode stuck");
	property p_vs; o_read_valid |-> $past(i_port_read); endproperty
	a_vs: assert property (p_vs) else $error("stray read");
endmodule
bind ndw_top ndw_chk #(
	.CNT_W(CNT_W)
) chk (
	.i_clk(i_clk),
	.i_rst(i_rst),
	.i_port_valid(i_port_valid),
	.i_port_read(i_port_read),
	.i_thresh_we(i_thresh_we),
	.i_thresh_wdata(i_thresh_wdata),
	.i_dl_ack(i_dl_ack),
	.i_refill_set(i_refill_set),
	.i_refill_clr(i_refill_clr),
	.o_read_valid(o_read_valid),
	.o_port_pop(o_port_pop),
	.o_refill_mode(o_refill_mode),
	.o_dl_irq(o_dl_irq),
	.o_refill_irq(o_refill_irq),
	.o_thresh(o_thresh)
);

// *** bench/ndw_handler.sv ***
// handler model reloading the refill word
`timescale 1ns/10ps
module ndw_handler (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic i_irq,
	output logic o_we = 1'b0,
	output logic [31:0] o_wd,
	output logic o_last
);
	int k = 0;
	// third word is marked as the last one
	always @(posedge i_clk) begin
		o_we <= i_go | i_irq;
		o_wd <= 32'ha0 + k;
		o_last <= k == 2;
		if (i_go | i_irq) k <= k + 1;
	end
endmodule

// *** bench/test_network_deadlock_watchdog_refill.sv ***
// testbench for the deadlock watchdog block
`timescale 1ns/10ps
module test_network_deadlock_watchdog_refill;
	logic c = 0, r = 1, v = 0, rd = 0, tw = 0, ak = 0, st = 0, sc = 0, go = 0;
	logic [31:0] pd = 0, p, tv = 0, wd, dat, th;
	logic we, la, rv, pop, md, dl, ri;
	int err_total = 0, n_tests = 0, n, k;
	ndw_top dut(.i_clk(c), .i_rst(r), .i_port_valid(v), .i_port_data(pd),
		.i_port_read(rd), .i_thresh_we(tw), .i_thresh_wdata(tv),
		.i_dl_ack(ak), .i_refill_set(st), .i_refill_clr(sc),
		.i_refill_we(we), .i_refill_wdata(wd), .i_refill_last(la),
		.o_read_data(dat), .o_read_valid(rv), .o_port_pop(pop),
		.o_refill_mode(md), .o_dl_irq(dl), .o_refill_irq(ri), .o_thresh(th));
	ndw_handler hm(.i_clk(c), .i_go(go), .i_irq(ri), .o_we(we), .o_wd(wd),
		.o_last(la));
	initial forever #2.5 c = ~c;
	task chk(input logic [63:0] g, e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#5000 err_total++;
		finish_test;
	end
	initial begin
		void'($urandom(32'hdd99));
		repeat (12) @(posedge c);
		r <= 0;
		#1 chk(th, 32'hffffffff);
		chk({dl, ri, rv, pop, md}, 5'h00);
		n = 4 + $urandom % 8;
		@(posedge c) {tw, tv} <= {1'b1, 32'(n)};
		@(posedge c) {tw, v} <= 2'b01;
		#1 chk(th, n);
		for (k = 0; k < 40 && dl !== 1; k++) @(posedge c) #1;
		chk(k >= n && k <= n + 4, 1);
		chk(k, n + 1);
		@(posedge c) v <= 0;
		repeat (4) @(posedge c);
		#1 chk(dl, 1);
		repeat (2) @(posedge c) ak <= 1;
		@(posedge c) ak <= 0;
		#1 chk(dl, 0);
		repeat (3 * n) @(posedge c) v <= ~v;
		@(posedge c) v <= 0;
		#1 chk(dl, 0);
		$display("watchdog test done");
		for (k = 0; k < 3 * n; k++) begin
			@(posedge c) {rd, v, p, pd} <= {2'b11, pd, 32'($urandom)};
			#1 if (k > 0) chk({rv, pop, dat}, {2'b11, p});
		end
		chk(dl, 0);
		@(posedge c) v <= 0;
		@(posedge c) #1 chk({rv, pop}, 2'b00);
		$display("read test done");
		@(posedge c) {rd, v, st, go} <= 4'b0011;
		@(posedge c) {st, go} <= 0;
		for (k = 0; k < 3; k++) begin
			@(posedge c) rd <= 1;
			@(posedge c) rd <= 0;
			#1 chk({ri, rv, pop, dat}, {3'b110, 32'ha0 + k});
			repeat (3) @(posedge c);
		end
		chk(md, 0);
		$display("refill test done");
		@(posedge c) st <= 1;
		@(posedge c) {st, sc} <= 2'b11;
		#1 chk(md, 1);
		@(posedge c) {st, sc} <= 2'b01;
		#1 chk(md, 1);
		@(posedge c) sc <= 0;
		#1 chk(md, 0);
		$display("mode test done");
		finish_test;
	end
endmodule
